//--- core/vsdg_core.sv
// Valley-synchronous duty and sync drive gating with time-based peak current limit
`include "vsdg_regs.svh"
`default_nettype none

// Notes on behaviour
// [RQ1] Positive half: arm when aux rises over 200 mV, fire when it drops under 100 mV.
// [RQ2] Negative half: arm when aux drops under 100 mV, fire when it rises over 200 mV.
// [RQ3] Valley-started duty pulse drives low side in positive half, high side in negative.
// [RQ4] Sync drive held off for the dead time after every duty falling edge.
// [RQ5] After dead time, sync turns on only if current sense exceeds the arm level.
// [RQ6] Sync stays on until current sense falls below the 50 mV trigger level.
// [RQ7] No duty pulse starts while current sense is above the trigger level.
// [RQ8] Sync pulses allowed only while line sense is above 220 mV; the code checks line sense only at sync turn-on, not during a sync pulse.
// [RQ9] Sync pulses allowed only after power-good output is high.
// [RQ10] Time above overcurrent level is accumulated and subtracted from full scale.
// [RQ11] Line-proportional ramp ends the on-time when it crosses the limit threshold.
// [RQ12] Optional mode cuts the limit threshold by 60 percent at high line.
// [RQ13] All comparator and polarity inputs pass two flip-flops before use.
module vsdg_core #(
  parameter int LINE_W = 12
) (
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_b,
  // Avalon-MM slave
  input  wire logic [3:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // Comparator and polarity pins
  input  wire logic              i_aux_above_hi,
  input  wire logic              i_aux_above_lo,
  input  wire logic              i_dcs_above_arm,
  input  wire logic              i_dcs_above_trig,
  input  wire logic              i_dcs_above_ovc,
  input  wire logic              i_line_sense_ok,
  input  wire logic              i_line_positive,
  // Line magnitude code from a converter on the core clock
  input  wire logic [LINE_W-1:0] i_line_sense_code,
  // Drives and status
  output logic                   o_low_side_duty_drive,
  output logic                   o_high_side_duty_drive,
  output logic                   o_power_good_out,
  output logic                   o_current_limit_trip
);

  if (LINE_W < 4 || LINE_W > 16) begin : g_bad_line_w
    $error("vsdg_core: LINE_W must lie in 4..16");
  end

  // --------------------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------------------
  logic [6:0] pins_s;
  logic       aux_hi_s;
  logic       aux_lo_s;
  logic       dcs_arm_s;
  logic       dcs_trig_s;
  logic       dcs_ovc_s;
  logic       line_ok_s;
  logic       pol_s;

  vsdg_sync #(
    .WIDTH (7)
  ) u_sync (  // RQ13
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .i_async   ({i_aux_above_hi, i_aux_above_lo, i_dcs_above_arm, i_dcs_above_trig,
                 i_dcs_above_ovc, i_line_sense_ok, i_line_positive}),
    .o_sync    (pins_s)
  );

  assign {aux_hi_s, aux_lo_s, dcs_arm_s, dcs_trig_s, dcs_ovc_s, line_ok_s, pol_s} = pins_s;

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [`VSDG_CTRL_W-1:0] ctrl_q;
  logic [15:0]             on_time_q;
  logic                    req;
  logic                    wr_go;
  logic [31:0]             wmask;
  logic                    enable;
  logic                    pg_q;
  logic                    hl_mode;

  assign req     = i_avs_read | i_avs_write;
  assign wr_go   = i_avs_write & ~o_avs_waitrequest;
  assign wmask   = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  assign enable  = ctrl_q[`VSDG_CTRL_EN_BIT];
  assign pg_q    = ctrl_q[`VSDG_CTRL_PG_BIT];
  assign hl_mode = ctrl_q[`VSDG_CTRL_HL_BIT];

  // One wait cycle per access; the answer comes at the second edge of the request
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~(req & o_avs_waitrequest);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q    <= `VSDG_CTRL_RST;
      on_time_q <= `VSDG_ON_TIME_RST;
    end else if (wr_go) begin
      if (i_avs_address == `VSDG_ADDR_CTRL) begin
        ctrl_q <= (ctrl_q & ~wmask[`VSDG_CTRL_W-1:0])
                | (i_avs_writedata[`VSDG_CTRL_W-1:0] & wmask[`VSDG_CTRL_W-1:0]);
      end
      if (i_avs_address == `VSDG_ADDR_ON_TIME) begin
        on_time_q <= (on_time_q & ~wmask[15:0]) | (i_avs_writedata[15:0] & wmask[15:0]);
      end
    end
  end

  // Power-good is a software-owned level here; it gates the sync drive
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_power_good_out <= 1'b0;
    end else begin
      o_power_good_out <= pg_q;
    end
  end

  // --------------------------------------------------------------------------
  // Gating state machine
  // --------------------------------------------------------------------------
  vsdg_pkg::vsdg_state_t state_q;
  vsdg_pkg::vsdg_state_t state_d;
  logic                  pol_q;
  logic                  pol_d;
  logic [15:0]           on_cnt_q;
  logic [3:0]            dead_cnt_q;
  logic                  armed;
  logic                  fire;
  logic                  on_done;
  logic                  cl_hit;

  // Same two comparators, roles swapped with line polarity
  assign armed   = pol_s ? aux_hi_s  : ~aux_lo_s;  // RQ1 RQ2
  assign fire    = pol_s ? ~aux_lo_s : aux_hi_s;   // RQ1 RQ2
  assign on_done = (on_cnt_q + 16'h0001) >= on_time_q;

  always_comb begin
    state_d = state_q;
    pol_d   = pol_q;
    if (!enable) begin
      state_d = vsdg_pkg::VSDG_IDLE;
    end else begin
      unique case (state_q)
        vsdg_pkg::VSDG_IDLE: begin
          state_d = vsdg_pkg::VSDG_ARM;
        end
        vsdg_pkg::VSDG_ARM: begin
          if (armed) begin
            state_d = vsdg_pkg::VSDG_TRIG;
          end
        end
        vsdg_pkg::VSDG_TRIG: begin
          if (fire && !dcs_trig_s) begin  // RQ7
            state_d = vsdg_pkg::VSDG_DUTY;
            pol_d   = pol_s;
          end
        end
        vsdg_pkg::VSDG_DUTY: begin
          if (on_done || cl_hit) begin  // RQ11
            state_d = vsdg_pkg::VSDG_DEAD;
          end
        end
        vsdg_pkg::VSDG_DEAD: begin
          if (dead_cnt_q == 4'(`VSDG_DEAD_CYC - 1)) begin  // RQ4
            state_d = vsdg_pkg::VSDG_SWAIT;
          end
        end
        vsdg_pkg::VSDG_SWAIT: begin
          if (!dcs_trig_s) begin  // RQ5
            state_d = vsdg_pkg::VSDG_ARM;
          end else if (dcs_arm_s && line_ok_s && o_power_good_out) begin  // RQ5 RQ8 RQ9
            state_d = vsdg_pkg::VSDG_SYNC;
          end
        end
        vsdg_pkg::VSDG_SYNC: begin
          if (!dcs_trig_s) begin  // RQ6
            state_d = vsdg_pkg::VSDG_ARM;
          end
        end
        default: begin
          state_d = vsdg_pkg::VSDG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= vsdg_pkg::VSDG_IDLE;
      pol_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      pol_q   <= pol_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      on_cnt_q   <= 16'h0000;
      dead_cnt_q <= 4'h0;
    end else begin
      on_cnt_q   <= (state_q == vsdg_pkg::VSDG_DUTY) ? on_cnt_q + 16'h0001 : 16'h0000;
      dead_cnt_q <= (state_q == vsdg_pkg::VSDG_DEAD) ? dead_cnt_q + 4'h1 : 4'h0;
    end
  end

  // Duty and sync sit on opposite switches of the fast leg
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_low_side_duty_drive  <= 1'b0;
      o_high_side_duty_drive <= 1'b0;
    end else begin
      o_low_side_duty_drive  <= (state_d == vsdg_pkg::VSDG_DUTY && pol_d)
                              || (state_d == vsdg_pkg::VSDG_SYNC && !pol_d);  // RQ3
      o_high_side_duty_drive <= (state_d == vsdg_pkg::VSDG_DUTY && !pol_d)
                              || (state_d == vsdg_pkg::VSDG_SYNC && pol_d);   // RQ3
    end
  end

  // --------------------------------------------------------------------------
  // Time-based peak current limit
  // --------------------------------------------------------------------------
  logic [15:0] os_acc_q;
  logic [15:0] thr_q;
  logic [15:0] thr_raw;
  logic [15:0] thr_eff;
  logic [23:0] ramp_q;
  logic        duty_start;
  logic [24:0] ramp_sum;

  assign duty_start = (state_d == vsdg_pkg::VSDG_DUTY) && (state_q != vsdg_pkg::VSDG_DUTY);
  assign thr_raw    = `VSDG_FULL_SCALE - os_acc_q;  // RQ10
  // Keep 40 percent of the threshold at high line when the option is on
  assign thr_eff    = (hl_mode && (16'(i_line_sense_code) >= 16'(`VSDG_HIGH_LINE)))
                    ? 16'((18'(thr_raw) << 1) / 18'd5) : thr_raw;  // RQ12
  assign cl_hit     = ramp_q >= {thr_q, 8'h00};  // RQ11
  // Saturate so a threshold near full scale is never skipped by wrap-around
  assign ramp_sum   = {1'b0, ramp_q} + 25'(i_line_sense_code);

  // Duration above the overcurrent level during 1-D, saturating
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      os_acc_q <= 16'h0000;
    end else if (duty_start) begin
      os_acc_q <= 16'h0000;
    end else if (dcs_ovc_s && state_q != vsdg_pkg::VSDG_DUTY) begin
      os_acc_q <= (os_acc_q > `VSDG_FULL_SCALE - `VSDG_OS_STEP)
                ? `VSDG_FULL_SCALE : os_acc_q + `VSDG_OS_STEP;  // RQ10
    end
  end

  // Threshold from the previous 1-D period is frozen for the whole on-time
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      thr_q  <= `VSDG_FULL_SCALE;
      ramp_q <= 24'h000000;
    end else begin
      if (duty_start) begin
        thr_q <= thr_eff;
      end
      ramp_q <= (state_q != vsdg_pkg::VSDG_DUTY) ? 24'h000000
              : (ramp_sum[24] ? 24'hffffff : ramp_sum[23:0]);  // RQ11
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_current_limit_trip <= 1'b0;
    end else begin
      o_current_limit_trip <= (state_q == vsdg_pkg::VSDG_DUTY) && cl_hit && !on_done;
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_avs_read && o_avs_waitrequest) begin
      unique case (i_avs_address)
        `VSDG_ADDR_CTRL:    o_avs_readdata <= {29'h0, ctrl_q};
        `VSDG_ADDR_ON_TIME: o_avs_readdata <= {16'h0000, on_time_q};
        `VSDG_ADDR_STATUS:  o_avs_readdata <= {16'h0000, 3'h0, line_ok_s, dcs_trig_s,
                                               pol_q, pol_s, state_q, 2'h0};
        `VSDG_ADDR_LIMIT:   o_avs_readdata <= {os_acc_q, thr_q};
        default:            o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic duty_on;
  logic sync_on;
  assign duty_on = state_q == vsdg_pkg::VSDG_DUTY;
  assign sync_on = state_q == vsdg_pkg::VSDG_SYNC;

  a_valley_fire: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)  // RQ1 RQ2
    $rose(duty_on) |-> $past(pol_s ? !aux_lo_s : aux_hi_s))
    else $error("duty pulse started without a valley event");
  a_valley_armed: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)  // RQ1 RQ2
    (state_q == vsdg_pkg::VSDG_ARM) && enable && !armed |=> state_q != vsdg_pkg::VSDG_TRIG)
    else $error("valley detector armed without arm condition");
  a_drive_side: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)  // RQ3
    duty_on |-> (o_low_side_duty_drive == pol_q) && (o_high_side_duty_drive == !pol_q))
    else $error("duty pulse on the wrong switch");
  a_dead_time: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)  // RQ4
    $fell(duty_on) |-> !sync_on [*7])
    else $error("sync drive inside dead time");
  a_sync_gates: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)  // RQ5 RQ8 RQ9
    $rose(sync_on) |-> $past(dcs_arm_s && line_ok_s && o_power_good_out))
    else $error("sync drive enabled without arm, line or power-good");
  a_sync_release: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)  // RQ6
    sync_on && !dcs_trig_s |=> !sync_on ##1 !(o_low_side_duty_drive && o_high_side_duty_drive))
    else $error("sync drive kept on below trigger level");
  a_duty_blank: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)  // RQ7
    $rose(duty_on) |-> $past(!dcs_trig_s))
    else $error("duty pulse started while current flows to the bulk");
  a_limit_stop: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)  // RQ10 RQ11
    duty_on && (ramp_q >= {thr_q, 8'h00}) |=> !duty_on ##1 !duty_on)
    else $error("on-time not ended at current limit");

endmodule // vsdg_core
`default_nettype wire

//--- core/vsdg_pkg.sv
// Types shared by the drive gating block
`default_nettype none
package vsdg_pkg;
  typedef enum logic [6:0] {
    VSDG_IDLE  = 7'b0000001,
    VSDG_ARM   = 7'b0000010,
    VSDG_TRIG  = 7'b0000100,
    VSDG_DUTY  = 7'b0001000,
    VSDG_DEAD  = 7'b0010000,
    VSDG_SWAIT = 7'b0100000,
    VSDG_SYNC  = 7'b1000000
  } vsdg_state_t;
endpackage
`default_nettype wire

//--- core/vsdg_regs.svh
// Register offsets, field positions, reset values and timing counts of the drive gating block
`ifndef VSDG_REGS_SVH
`define VSDG_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define VSDG_ADDR_CTRL      4'h0
`define VSDG_ADDR_ON_TIME   4'h4
`define VSDG_ADDR_STATUS    4'h8
`define VSDG_ADDR_LIMIT     4'hc

// ----------------------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------------------
`define VSDG_CTRL_EN_BIT    0
`define VSDG_CTRL_PG_BIT    1
`define VSDG_CTRL_HL_BIT    2
`define VSDG_CTRL_W         3
`define VSDG_CTRL_RST       3'h0
`define VSDG_ON_TIME_RST    16'h00fa

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define VSDG_CLK_NS         20
`define VSDG_DEAD_NS        130
`define VSDG_DEAD_CYC       ((`VSDG_DEAD_NS + `VSDG_CLK_NS - 1) / `VSDG_CLK_NS)

// ----------------------------------------------------------------------------
// Current limit scaling: full scale code stands for 5 V
// ----------------------------------------------------------------------------
`define VSDG_FULL_SCALE     16'hffff
`define VSDG_OS_STEP        16'h0040
`define VSDG_HIGH_LINE      12'h800

`endif

//--- core/vsdg_sync.sv
// Two-stage synchroniser for a vector of asynchronous levels
`default_nettype none
module vsdg_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("vsdg_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // vsdg_sync
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the drive gating block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic       pos;
    logic       heavy;
    logic       line_ok;
    logic [2:0] ctrl;
    logic       sync_exp;
  } vsdgt_row_t;
  logic        clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [3:0]  addr = 4'h0, be = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic        waitreq, aux, arm, trig, ovc, lo, hi, pg, trip, duty;
  logic        pos = 1'b1, line_ok = 1'b0, heavy = 1'b0, surge = 1'b0, trip_seen = 1'b0;
  logic [11:0] code = 12'h100;
  logic [7:0]  ovc_len = 8'h00;
  int          n_fail = 0, checked = 0, cyc = 0, w, e;
  vsdgt_row_t  rows [5] = '{
    '{1'b1, 1'b1, 1'b1, 3'h3, 1'b1},
    '{1'b0, 1'b1, 1'b1, 3'h3, 1'b1},
    '{1'b1, 1'b0, 1'b1, 3'h3, 1'b0},
    '{1'b0, 1'b1, 1'b0, 3'h3, 1'b0},
    '{1'b1, 1'b1, 1'b1, 3'h1, 1'b0}
  };
  // ---------------------------------------------------------------
  // Design, power stage and clock
  // ---------------------------------------------------------------
  assign duty = pos ? lo : hi;
  vsdg_core DUT (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_aux_above_hi(aux), .i_aux_above_lo(aux), .i_dcs_above_arm(arm),
    .i_dcs_above_trig(trig), .i_dcs_above_ovc(ovc), .i_line_sense_ok(line_ok),
    .i_line_positive(pos), .i_line_sense_code(code),
    .o_low_side_duty_drive(lo), .o_high_side_duty_drive(hi),
    .o_power_good_out(pg), .o_current_limit_trip(trip)
  );
  vsdg_stage_model stage (
    .i_sys_clk(clk), .i_duty(duty), .i_heavy(heavy), .i_surge(surge),
    .i_ovc_len(ovc_len), .o_aux_above(aux), .o_arm(arm), .o_trig(trig), .o_ovc(ovc)
  );
  initial begin
    forever #10 clk = ~clk;
  end
  always @(negedge clk) if (trip === 1'b1) trip_seen = 1'b1;
  // Ceiling well above the roughly 15k cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      test_done();
    end
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic bit cmp(input logic [31:0] a, input logic [31:0] b);
    checked++;
    return a !== b;
  endfunction
  task automatic err(input string m);
    n_fail++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic test_done();
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic bus(input logic w_i, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    be    <= b;
    wr    <= w_i;
    rd    <= !w_i;
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  function automatic logic sv(input logic p);
    return p ? hi : lo;
  endfunction
  // Disable, then wait out on-time and discharge so the next case starts clean
  task automatic settle();
    bus(1'b1, 4'h0, 32'h0, 4'hf);
    repeat (150) @(posedge clk);
  endtask
  task automatic pulse(input logic p, input logic s);
    int n;
    n = 0;
    w = 0;
    while (!sv(!p) && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (cmp(sv(!p), 1'b1)) err("duty pulse missing");
    while (sv(!p) === 1'b1 && w < 70000) begin
      if (cmp(sv(p), 1'b0)) err("drives overlap");
      @(negedge clk);
      w++;
    end
    n = 0;
    while (sv(p) !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (!s) begin
      if (cmp(n, 60)) err("sync pulse not withheld");
    end else begin
      if (cmp(n >= 7 && n < 60, 1'b1)) err("sync dead time or enable");
      while (trig !== 1'b0) @(negedge clk);
      n = 0;
      while (sv(p) === 1'b1 && n < 10) begin
        @(negedge clk);
        n++;
      end
      if (cmp(n, 3)) err("sync turn-off delay");
    end
  endtask
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    if (cmp({lo, hi, pg, trip, waitreq}, 5'b00001)) err("outputs in reset");
    rst_b <= 1'b1;
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    if (cmp(q, 32'h000000fa)) err("on-time reset value");
    bus(1'b1, 4'h4, 32'h12345678, 4'h1);
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    if (cmp(q, 32'h00000078)) err("byte lane write");
    bus(1'b1, 4'h1, 32'hffffffff, 4'hf);
    bus(1'b0, 4'h1, 32'h0, 4'hf);
    if (cmp(q, 32'h0)) err("unmapped read");
    bus(1'b1, 4'h4, 32'h0000000a, 4'hf);
    for (int i = 0; i < 5; i++) begin
      settle();
      pos     <= rows[i].pos;
      heavy   <= rows[i].heavy;
      line_ok <= rows[i].line_ok;
      bus(1'b1, 4'h0, {29'h0, rows[i].ctrl}, 4'hf);
      pulse(rows[i].pos, rows[i].sync_exp);
      pulse(rows[i].pos, rows[i].sync_exp);
      if (cmp(w, 10)) err("duty width");
      if (cmp(pg, rows[i].ctrl[1])) err("power good copy");
    end
    // Surge: current toward the bulk holds off duty pulses
    settle();
    bus(1'b1, 4'h0, 32'h3, 4'hf);
    pulse(1'b1, 1'b1);
    @(posedge clk);
    surge <= 1'b1;
    repeat (20) @(negedge clk);
    for (int i = 0; i < 150; i++) begin
      if (cmp(lo, 1'b0)) err("duty during surge");
      @(negedge clk);
    end
    @(posedge clk);
    surge <= 1'b0;
    pulse(1'b1, 1'b1);
    // Ramp limit at full line, then with the high-line cut
    settle();
    bus(1'b1, 4'h4, 32'h0000ffff, 4'hf);
    code    <= 12'hfff;
    ovc_len <= 8'h40;
    bus(1'b1, 4'h0, 32'h3, 4'hf);
    pulse(1'b1, 1'b1);
    trip_seen = 1'b0;
    pulse(1'b1, 1'b1);
    e = (32'hefff * 256) / 4095;
    if (cmp(w > e - 5 && w < e + 5, 1'b1)) err("ramp limit on-time");
    if (cmp(trip_seen, 1'b1)) err("limit trip missing");
    bus(1'b1, 4'h0, 32'h7, 4'hf);
    pulse(1'b1, 1'b1);
    pulse(1'b1, 1'b1);
    e = ((32'hefff * 2 / 5) * 256) / 4095;
    if (cmp(w > e - 5 && w < e + 5, 1'b1)) err("high-line cut on-time");
    // 64 cycles above the overcurrent level add 0x1000; cut keeps 2/5 of 0xefff
    bus(1'b0, 4'hc, 32'h0, 4'hf);
    if (cmp(q, {16'h1000, 16'h5fff})) err("limit accumulator or threshold");
    // Reset in mid-run clears the drives and the control word
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    if (cmp({lo, hi, pg, trip, waitreq}, 5'b00001)) err("outputs in mid-run reset");
    rst_b <= 1'b1;
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    if (cmp(q, 32'h0)) err("control after mid-run reset");
    test_done();
  end
endmodule // tb_top
`default_nettype wire

//--- verification/vsdg_stage_model.sv
// Power-stage model: aux winding ringing and discharge current comparators
`default_nettype none
module vsdg_stage_model (
  // Clock and duty drive of the active half cycle
  input  wire logic       i_sys_clk,
  input  wire logic       i_duty,
  // Load and fault knobs
  input  wire logic       i_heavy,
  input  wire logic       i_surge,
  input  wire logic [7:0] i_ovc_len,
  // Comparator outputs
  output logic            o_aux_above,
  output logic            o_arm,
  output logic            o_trig,
  output logic            o_ovc
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DIS_LEN = 8'h64;
  logic       duty_q = 1'b0;
  logic [7:0] dis_q  = 8'h00;
  logic [3:0] ring_q = 4'h0;
  // Ringing runs on through the on-time, so the block must pick its own edge
  always_ff @(posedge i_sys_clk) begin
    duty_q <= i_duty;
    ring_q <= ring_q + 4'h1;
    if (duty_q && !i_duty) begin
      dis_q <= DIS_LEN;
    end else if (dis_q != 8'h00) begin
      dis_q <= dis_q - 8'h01;
    end
  end
  assign o_aux_above = ring_q[3];
  assign o_trig      = i_surge || (dis_q != 8'h00);
  assign o_arm       = i_heavy && (dis_q > DIS_LEN - 8'h1e);
  assign o_ovc       = dis_q > DIS_LEN - i_ovc_len;
endmodule // vsdg_stage_model
`default_nettype wire
